// >>> sixteen_bit_timer_mode_control_tb_top.sv
// Self-checking bench: APB master, pin model, modes, clocking and capture.
// Assumes a one-access-cycle APB slave and all registers reset to zero.
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_mode_control_tb_top;
  import timer16_pkg::*;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err_flag;
  logic [7:0]  paddr, rdat;
  logic [31:0] pwdata, prdata;
  logic        cap_pin, cnt_pin, wave_a, wave_b, en_a, en_b;
  logic [15:0] val, got;
  int          err_total, cmp_count, k;
  int          cycles = 0;
  logic [1:0]  com_seq [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic        exp_seq [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [3:0]  m_tab   [5] = '{4'h0, 4'h4, 4'h5, 4'h1, 4'h8};
  logic [15:0] s_tab   [5] = '{16'hFFF0, 16'hFFF0, 16'h00F0, 16'h00F0, 16'h0008};
  logic [7:0]  f_tab   [5] = '{8'h03, 8'h02, 8'h01, 8'h00, 8'h09};
  int          div_tab [4] = '{8, 64, 256, 1024};

  timer16_ctrl u_dut (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .capture_input_pin_i(cap_pin),
    .external_count_pin_i(cnt_pin), .wave_output_a_o(wave_a), .wave_output_b_o(wave_b),
    .wave_enable_a_o(en_a), .wave_enable_b_o(en_b));
  timer16_pin_model u_pins (.clk_i(clk), .capture_input_pin_o(cap_pin),
    .external_count_pin_o(cnt_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard: the slowest prescaler pass dominates the run time
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata[7:0];
    err_flag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(nm, {8'h00, e}, {8'h00, rdat});
  endtask
  // High byte first on writes, low byte first on reads
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h04, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    apb(1'b0, lo, 8'h00);
    v[7:0] = rdat;
    apb(1'b0, lo + 8'h04, 8'h00);
    v[15:8] = rdat;
  endtask
  // Reserved bit 5 always written as zero
  function automatic logic [7:0] ctl_b(input logic [3:0] m, input logic [2:0] cs,
                                       input logic [1:0] cap);
    return {cap, 1'b0, m[3:2], cs};
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(52));
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rdc("ctrl_a", OFS_CTRL_A, CTRL_RST);
    rdc("ctrl_b", OFS_CTRL_B, CTRL_RST);
    rdc("cnt_lo", OFS_CNT_LO, 8'h00);
    apb(1'b1, 8'h30, 8'hFF);
    check("slverr", 16'h0001, {15'h0000, err_flag});
    val = 16'($urandom());
    wr16(OFS_CNT_LO, val);
    rd16(OFS_CNT_LO, got);
    check("counter", val, got);
    wr16(OFS_CMPA_LO, ~val);
    rd16(OFS_CMPA_LO, got);
    check("cmp_a", ~val, got);
    wr(OFS_CTRL_B, ctl_b(4'h4, CS_STOP, 2'h0));
    wr(OFS_FLAGS, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL_A, {com_seq[i], com_seq[i], 4'h0});
      wr(OFS_CTRL_C, 8'hC0);
      repeat (3) @(posedge clk);
      check("wave_a", {15'h0000, exp_seq[i]}, {15'h0000, wave_a});
      check("wave_b", {15'h0000, exp_seq[i]}, {15'h0000, wave_b});
      check("en_a", 16'h0001, {15'h0000, en_a});
      check("en_b", 16'h0001, {15'h0000, en_b});
    end
    rdc("ctrl_c", OFS_CTRL_C, 8'h00);
    rdc("flags_force", OFS_FLAGS, 8'h00);
    rd16(OFS_CNT_LO, got);
    check("force_cnt", val, got);
    for (int i = 0; i < 4; i++) begin
      wr16(OFS_CNT_LO, 16'h0000);
      wr(OFS_CTRL_B, ctl_b(4'h0, 3'(i + 2), 2'h0));
      repeat (10 * div_tab[i]) @(posedge clk);
      wr(OFS_CTRL_B, ctl_b(4'h0, CS_STOP, 2'h0));
      rd16(OFS_CNT_LO, got);
      check("prescale", 16'h0001, {15'h0000, got >= 16'h0009 && got <= 16'h000B});
    end
    wr16(OFS_CMPA_LO, 16'hFFF8);
    wr16(OFS_CMPB_LO, 16'hFFF0);
    wr16(OFS_CAP_LO, 16'h0010);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL_B, ctl_b(m_tab[i], CS_STOP, 2'h0));
      wr(OFS_CTRL_A, {6'h00, m_tab[i][1:0]});
      wr(OFS_CTRL_C, 8'h00);
      wr16(OFS_CNT_LO, s_tab[i]);
      wr(OFS_FLAGS, 8'h0F);
      wr(OFS_CTRL_B, ctl_b(m_tab[i], CS_DIV1, 2'h0));
      repeat (40) @(posedge clk);
      wr(OFS_CTRL_B, ctl_b(m_tab[i], CS_STOP, 2'h0));
      rdc("mode_flags", OFS_FLAGS, f_tab[i]);
    end
    wr(OFS_CTRL_A, 8'h00);
    wr16(OFS_CNT_LO, 16'h0000);
    k = $urandom_range(8, 1);
    wr(OFS_CTRL_B, ctl_b(4'h0, 3'h7, 2'h0));
    u_pins.count_pulses(k);
    wr(OFS_CTRL_B, ctl_b(4'h0, CS_EXTF, 2'h0));
    u_pins.count_pulses(k);
    wr(OFS_CTRL_B, ctl_b(4'h0, CS_STOP, 2'h0));
    rd16(OFS_CNT_LO, got);
    check("ext_count", 16'(2 * k), got);
    for (int e = 0; e < 2; e++) begin
      val = 16'($urandom());
      wr16(OFS_CNT_LO, val);
      wr(OFS_CTRL_B, ctl_b(4'h0, CS_STOP, {1'b0, e[0]}));
      wr(OFS_FLAGS, 8'h0F);
      u_pins.cap_hold(1'b1, 8);
      rdc("cap_rise", OFS_FLAGS, {4'h0, e[0], 3'h0});
      u_pins.cap_hold(1'b0, 8);
      rdc("cap_fall", OFS_FLAGS, 8'h08);
      rd16(OFS_CAP_LO, got);
      check("capture", val, got);
    end
    wr(OFS_CTRL_B, ctl_b(4'h0, CS_STOP, 2'h3));
    wr(OFS_FLAGS, 8'h0F);
    u_pins.cap_hold(1'b1, 2);
    u_pins.cap_hold(1'b0, 10);
    rdc("filt_short", OFS_FLAGS, 8'h00);
    u_pins.cap_hold(1'b1, 10);
    rdc("filt_long", OFS_FLAGS, 8'h08);
    u_pins.cap_hold(1'b0, 10);
    wr(OFS_CTRL_B, ctl_b(4'hC, CS_STOP, 2'h1));
    wr(OFS_FLAGS, 8'h0F);
    u_pins.cap_hold(1'b1, 10);
    rdc("cap_as_top", OFS_FLAGS, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> timer16_ctrl.sv
// 16-bit timer/counter control: modes, clocking, capture, compare, APB regs.
// Assumes pins arrive asynchronously and the CPU keeps high-first write order.
`timescale 1ns/1ps
`default_nettype none

module timer16_ctrl
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Pins
  input  wire logic        capture_input_pin_i,
  input  wire logic        external_count_pin_i,
  output logic             wave_output_a_o,
  output logic             wave_output_b_o,
  output logic             wave_enable_a_o,
  output logic             wave_enable_b_o
);
  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic seq_kind_t kind_of(input logic [3:0] m);
    case (m)
      4'd0:                      kind_of = K_NORM;
      4'd4, 4'd12:               kind_of = K_CTC;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: kind_of = K_FAST;
      4'd1, 4'd2, 4'd3, 4'd10, 4'd11: kind_of = K_PHASE;
      4'd8, 4'd9:                kind_of = K_PFC;
      default:                   kind_of = K_RSVD;
    endcase
  endfunction
  function automatic top_src_t src_of(input logic [3:0] m);
    case (m)
      4'd8, 4'd10, 4'd12, 4'd14: src_of = TS_CAP;
      4'd4, 4'd9, 4'd11, 4'd15:  src_of = TS_CMPA;
      default:                   src_of = TS_FIX;
    endcase
  endfunction
  function automatic logic [15:0] fixed_top(input logic [1:0] low);
    case (low)
      2'd1:    fixed_top = TOP_8;
      2'd2:    fixed_top = TOP_9;
      2'd3:    fixed_top = TOP_10;
      default: fixed_top = TOP_MAX;
    endcase
  endfunction
  // Output pin action for a match: hold, toggle, clear, set
  function automatic logic act(input logic [1:0] com, input logic cur);
    case (com)
      2'b01:   act = ~cur;
      2'b10:   act = 1'b0;
      2'b11:   act = 1'b1;
      default: act = cur;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  ctrl_a, ctrl_b, temp_hi, rd_hi;
  logic [15:0] cnt, cmpa, cmpb, cmpa_buf, cmpb_buf, cap_reg;
  logic [3:0]  flags;
  logic        dir_up, block_match;
  logic [9:0]  presc;
  logic [2:0]  cap_sync, ext_sync;
  logic [3:0]  filt_sh;
  logic        cap_stable, cap_lvl, ext_lvl;
  logic        next_pready, next_pslverr, next_wa, next_wb, next_ea, next_eb;
  logic [31:0] next_prdata;
  logic [7:0]  next_ctrl_a, next_ctrl_b, next_temp_hi, next_rd_hi;
  logic [15:0] next_cnt, next_cmpa, next_cmpb, next_cmpa_buf, next_cmpb_buf;
  logic [15:0] next_cap_reg;
  logic [3:0]  next_flags, next_filt_sh;
  logic        next_dir_up, next_block_match, next_cap_stable, next_cap_lvl;
  logic        next_ext_lvl;
  logic [9:0]  next_presc;

  // ****************************************
  // Combinational view
  // ****************************************
  logic [3:0]  mode;
  seq_kind_t   kind;
  top_src_t    tsrc;
  logic [15:0] top;
  logic        pwm, tick, at_top, at_bot, match_a, match_b, cap_evt;
  logic        wr_en, rd_setup, cnt_wr, frc_a, frc_b, upd_pt, tov_pt;
  logic        cap_new;

  assign mode = {ctrl_b[4:3], ctrl_a[1:0]};
  assign kind = kind_of(mode);
  assign tsrc = src_of(mode);
  // reserved mode counts freely, with no top, update or overflow point
  assign top  = (tsrc == TS_CAP) ? cap_reg : (tsrc == TS_CMPA) ? cmpa : fixed_top(mode[1:0]);
  assign pwm  = (kind != K_NORM) && (kind != K_CTC);
  assign wr_en    = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign cnt_wr   = wr_en && (paddr_i == OFS_CNT_LO || paddr_i == OFS_CNT_HI);
  assign frc_a    = wr_en && paddr_i == OFS_CTRL_C && pwdata_i[B_FRC_A] && !pwm;
  assign frc_b    = wr_en && paddr_i == OFS_CTRL_C && pwdata_i[B_FRC_B] && !pwm;
  always_comb begin
    case (ctrl_b[2:0])
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &presc[2:0];
      CS_D64:  tick = &presc[5:0];
      CS_D256: tick = &presc[7:0];
      CS_D1K:  tick = &presc[9:0];
      // external pin edges: falling edge for CS_EXTF, rising edge for code 7
      CS_EXTF: tick = ext_lvl && !next_ext_lvl;
      default: tick = !ext_lvl && next_ext_lvl;
    endcase
  end
  assign at_top = (cnt == top);
  assign at_bot = (cnt == WORD_RST);
  // suppressed right after a counter write
  assign match_a = tick && !block_match && (cnt == cmpa);
  assign match_b = tick && !block_match && (cnt == cmpb);
  // Update and overflow points per family
  always_comb begin
    case (kind)
      K_NORM:  begin upd_pt = 1'b1; tov_pt = cnt == TOP_MAX; end
      K_CTC:   begin upd_pt = 1'b1; tov_pt = cnt == TOP_MAX; end
      // fast PWM update and overflow at TOP
      K_FAST:  begin upd_pt = at_top; tov_pt = at_top; end
      // phase correct update at TOP, overflow at BOTTOM
      K_PHASE: begin upd_pt = at_top; tov_pt = at_bot; end
      // phase-frequency correct at BOTTOM for both
      K_PFC:   begin upd_pt = at_bot; tov_pt = at_bot; end
      default: begin upd_pt = 1'b0; tov_pt = 1'b0; end
    endcase
  end
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [7:0] rd_lo;
    logic       la, lb;
    logic [3:0] hw_set;
    rd_lo = 8'h00;
    la    = 1'b0;
    lb    = 1'b0;
    next_ctrl_a = ctrl_a;   next_ctrl_b = ctrl_b;   next_temp_hi = temp_hi;
    next_rd_hi  = rd_hi;    next_cnt    = cnt;      next_cmpa    = cmpa;
    next_cmpb   = cmpb;     next_cmpa_buf = cmpa_buf; next_cmpb_buf = cmpb_buf;
    next_cap_reg = cap_reg; hw_set      = 4'h0;     next_dir_up  = dir_up;
    next_presc  = presc + 10'h001;
    next_wa = wave_output_a_o;
    next_wb = wave_output_b_o;
    next_block_match = block_match;
    // Pin conditioning: a change counts once stages two and three agree
    next_cap_stable = (cap_sync[2] == cap_sync[1]) ? cap_sync[2] : cap_stable;
    next_ext_lvl    = (ext_sync[2] == ext_sync[1]) ? ext_sync[2] : ext_lvl;
    // four equal samples before the filtered level moves
    next_filt_sh = {filt_sh[FILT_LEN-2:0], next_cap_stable};
    if (ctrl_b[B_FILT])
      next_cap_lvl = (&filt_sh) ? 1'b1 : (~|filt_sh) ? 1'b0 : cap_lvl;
    else
      next_cap_lvl = cap_stable;
    // edge polarity from the select bit
    cap_new = ctrl_b[B_EDGE] ? (!cap_lvl && next_cap_lvl) : (cap_lvl && !next_cap_lvl);
    // no capture while the capture register is TOP
    cap_evt = cap_new && (tsrc != TS_CAP);
    // Counter sequence
    if (tick) begin
      next_block_match = 1'b0;
      case (kind)
        K_CTC, K_FAST: next_cnt = at_top ? WORD_RST : cnt + 16'h0001;
        K_PHASE, K_PFC: begin
          if (dir_up && at_top) begin
            next_dir_up = 1'b0;
            next_cnt    = cnt - 16'h0001;
          end else if (!dir_up && at_bot) begin
            next_dir_up = 1'b1;
            next_cnt    = cnt + 16'h0001;
          end else begin
            next_cnt = dir_up ? cnt + 16'h0001 : cnt - 16'h0001;
          end
        end
        default: next_cnt = cnt + 16'h0001;
      endcase
      if (tov_pt)
        hw_set[F_TOV] = 1'b1;
      if (tsrc == TS_CAP && at_top)
        hw_set[F_ICF] = 1'b1;
      if (upd_pt) begin
        next_cmpa = cmpa_buf;
        next_cmpb = cmpb_buf;
      end
    end
    // capture copies the counter and sets the flag
    if (cap_evt) begin
      next_cap_reg      = cnt;
      hw_set[F_ICF]     = 1'b1;
    end
    // Waveform actions on real and forced matches
    // forced matches stay out of flags and the count sequence
    if (match_a) hw_set[F_OCFA] = 1'b1;
    if (match_b) hw_set[F_OCFB] = 1'b1;
    if (!pwm) begin
      // forced match uses current output mode
      if (match_a || frc_a) next_wa = act(ctrl_a[7:6], wave_output_a_o);
      if (match_b || frc_b) next_wb = act(ctrl_a[5:4], wave_output_b_o);
    end else begin
      la = (kind == K_FAST) ? 1'b0 : !dir_up;
      lb = la;
      if (ctrl_a[7]) begin
        if (match_a) next_wa = ctrl_a[6] ^ la;
        else if (tick && kind == K_FAST && at_top) next_wa = !ctrl_a[6];
      end else if (ctrl_a[6] && mode[3] && match_a) begin
        next_wa = !wave_output_a_o;
      end
      if (ctrl_a[5]) begin
        if (match_b) next_wb = ctrl_a[4] ^ lb;
        else if (tick && kind == K_FAST && at_top) next_wb = !ctrl_a[4];
      end
    end
    // Bus reads: snapshot at setup, side effect commits at the access edge
    case (paddr_i)
      OFS_CTRL_A:  rd_lo = ctrl_a & 8'hF3;
      OFS_CTRL_B:  rd_lo = ctrl_b & 8'hDF;
      OFS_CTRL_C:  rd_lo = 8'h00;
      // low read parks the high byte in the temp register
      OFS_CNT_LO:  rd_lo = cnt[7:0];
      OFS_CAP_LO:  rd_lo = cap_reg[7:0];
      OFS_CNT_HI, OFS_CAP_HI: rd_lo = temp_hi;
      OFS_CMPA_LO: rd_lo = cmpa_buf[7:0];
      OFS_CMPA_HI: rd_lo = cmpa_buf[15:8];
      OFS_CMPB_LO: rd_lo = cmpb_buf[7:0];
      OFS_CMPB_HI: rd_lo = cmpb_buf[15:8];
      OFS_FLAGS:   rd_lo = {4'h0, flags};
      default:     rd_lo = 8'h00;
    endcase
    next_pready  = psel_i && !penable_i;
    next_prdata  = rd_setup ? {24'h000000, rd_lo} : prdata_o;
    next_pslverr = psel_i && !penable_i && (paddr_i > OFS_FLAGS || paddr_i[1:0] != 2'b00);
    if (rd_setup)
      next_rd_hi = (paddr_i == OFS_CAP_LO) ? cap_reg[15:8] : cnt[15:8];
    if (psel_i && penable_i && pready_o && !pwrite_i &&
        (paddr_i == OFS_CNT_LO || paddr_i == OFS_CAP_LO))
      next_temp_hi = rd_hi;
    next_flags = flags | hw_set;
    // Bus writes
    if (wr_en && !pslverr_o) begin
      case (paddr_i)
        OFS_CTRL_A: next_ctrl_a = pwdata_i[7:0] & 8'hF3;
        OFS_CTRL_B: next_ctrl_b = pwdata_i[7:0] & 8'hDF;
        OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI, OFS_CAP_HI: next_temp_hi = pwdata_i[7:0];
        // and the next timer clock sees no match
        OFS_CNT_LO: begin
          next_cnt         = {temp_hi, pwdata_i[7:0]};
          next_block_match = 1'b1;
        end
        OFS_CMPA_LO: begin
          next_cmpa_buf = {temp_hi, pwdata_i[7:0]};
          if (!pwm) next_cmpa = {temp_hi, pwdata_i[7:0]};
        end
        OFS_CMPB_LO: begin
          next_cmpb_buf = {temp_hi, pwdata_i[7:0]};
          if (!pwm) next_cmpb = {temp_hi, pwdata_i[7:0]};
        end
        OFS_CAP_LO: next_cap_reg = {temp_hi, pwdata_i[7:0]};
        // Hardware set wins over a same-cycle clear
        OFS_FLAGS: next_flags = (flags & ~pwdata_i[3:0]) | hw_set;
        default: ;
      endcase
    end
    next_ea = ctrl_a[7:6] != 2'b00;
    next_eb = ctrl_a[5:4] != 2'b00;
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_sync <= 3'h0;  ext_sync <= 3'h0;  filt_sh <= 4'h0;
      cap_stable <= 1'b0; cap_lvl <= 1'b0;  ext_lvl <= 1'b0;
      ctrl_a <= CTRL_RST; ctrl_b <= CTRL_RST; temp_hi <= CTRL_RST; rd_hi <= CTRL_RST;
      cnt <= WORD_RST;   cmpa <= WORD_RST;  cmpb <= WORD_RST;
      cmpa_buf <= WORD_RST; cmpb_buf <= WORD_RST; cap_reg <= WORD_RST;
      flags <= 4'h0;     dir_up <= 1'b1;    block_match <= 1'b0; presc <= 10'h000;
      pready_o <= 1'b0;  prdata_o <= 32'h00000000; pslverr_o <= 1'b0;
      wave_output_a_o <= 1'b0; wave_output_b_o <= 1'b0;
      wave_enable_a_o <= 1'b0; wave_enable_b_o <= 1'b0;
    end else begin
      cap_sync <= {cap_sync[1:0], capture_input_pin_i};
      ext_sync <= {ext_sync[1:0], external_count_pin_i};
      filt_sh <= next_filt_sh; cap_stable <= next_cap_stable;
      cap_lvl <= next_cap_lvl; ext_lvl <= next_ext_lvl;
      ctrl_a <= next_ctrl_a; ctrl_b <= next_ctrl_b;
      temp_hi <= next_temp_hi; rd_hi <= next_rd_hi;
      cnt <= next_cnt; cmpa <= next_cmpa; cmpb <= next_cmpb;
      cmpa_buf <= next_cmpa_buf; cmpb_buf <= next_cmpb_buf; cap_reg <= next_cap_reg;
      flags <= next_flags; dir_up <= next_dir_up;
      block_match <= next_block_match; presc <= next_presc;
      pready_o <= next_pready; prdata_o <= next_prdata; pslverr_o <= next_pslverr;
      wave_output_a_o <= next_wa; wave_output_b_o <= next_wb;
      wave_enable_a_o <= next_ea; wave_enable_b_o <= next_eb;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_mode_join;
    tick && kind == K_FAST && at_top |=> cnt == WORD_RST;
  endproperty
  a_mode_join: assert property (p_mode_join) else $error("fast mode did not wrap");
  property p_norm_tov;
    tick && mode == 4'd0 && cnt == TOP_MAX |=> flags[F_TOV] && cnt == WORD_RST;
  endproperty
  a_norm_tov: assert property (p_norm_tov) else $error("normal overflow missing");
  property p_phase_turn;
    tick && kind == K_PHASE && dir_up && at_top |=> !dir_up && cnt == $past(top) - 16'h0001;
  endproperty
  a_phase_turn: assert property (p_phase_turn) else $error("phase turn wrong");
  property p_stop;
    ctrl_b[2:0] == CS_STOP && !cnt_wr |=> $stable(cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer counted");
  property p_cap_off;
    tsrc == TS_CAP && !wr_en |=> $stable(cap_reg);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture while TOP");
  property p_cap_copy;
    cap_evt && !wr_en |=> cap_reg == $past(cnt) && flags[F_ICF];
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture copy wrong");
  property p_block;
    cnt_wr && paddr_i == OFS_CNT_LO |=> block_match;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");
  sequence s_force_read;
    psel_i && !penable_i && !pwrite_i && paddr_i == OFS_CTRL_C;
  endsequence
  property p_force_zero;
    s_force_read |=> pready_o && prdata_o == 32'h00000000;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force bits read");
  property p_force_noflag;
    frc_a && !match_a && !flags[F_OCFA] && !(wr_en && paddr_i == OFS_FLAGS) |=> !flags[F_OCFA];
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set flag");
endmodule

`default_nettype wire

// >>> timer16_pin_model.sv
// Far-side pin model: drives the capture pin and the external count pin.
// Assumes the caller runs one task at a time, clocked by the bus clock.
`timescale 1ns/1ps
`default_nettype none
module timer16_pin_model (
  // Clock
  input  wire logic clk_i,
  // Pins
  output logic      capture_input_pin_o,
  output logic      external_count_pin_o
);
  initial begin
    capture_input_pin_o  = 1'b0;
    external_count_pin_o = 1'b0;
  end
  // ****************************************
  // Pin tasks
  // ****************************************
  // Level stands n+1 cycles, long enough to cross the input synchroniser
  task automatic cap_hold(input logic lvl, input int n);
    @(posedge clk_i);
    capture_input_pin_o <= lvl;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic count_pulses(input int k);
    repeat (k) begin
      @(posedge clk_i);
      external_count_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      external_count_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> timer16_pkg.sv
// Constants for the 16-bit timer control block: register map, fields, modes.
// Assumes a 32-bit APB slave carrying byte-wide registers in the low lanes.
package timer16_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] OFS_CTRL_C  = 8'h08;
  localparam logic [7:0] OFS_CNT_LO  = 8'h0C;
  localparam logic [7:0] OFS_CNT_HI  = 8'h10;
  localparam logic [7:0] OFS_CMPA_LO = 8'h14;
  localparam logic [7:0] OFS_CMPA_HI = 8'h18;
  localparam logic [7:0] OFS_CMPB_LO = 8'h1C;
  localparam logic [7:0] OFS_CMPB_HI = 8'h20;
  localparam logic [7:0] OFS_CAP_LO  = 8'h24;
  localparam logic [7:0] OFS_CAP_HI  = 8'h28;
  localparam logic [7:0] OFS_FLAGS   = 8'h2C;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_FILT  = 7;
  localparam int B_EDGE  = 6;
  localparam int B_RSVD  = 5;
  localparam int B_FRC_A = 7;
  localparam int B_FRC_B = 6;
  localparam int F_TOV   = 0;
  localparam int F_OCFA  = 1;
  localparam int F_OCFB  = 2;
  localparam int F_ICF   = 3;
  // ****************************************
  // Reset values and fixed tops
  // ****************************************
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] TOP_MAX  = 16'hFFFF;
  localparam logic [15:0] TOP_8    = 16'h00FF;
  localparam logic [15:0] TOP_9    = 16'h01FF;
  localparam logic [15:0] TOP_10   = 16'h03FF;
  localparam int          FILT_LEN = 4;
  // ****************************************
  // Clock select codes
  // ****************************************
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_D64  = 3'h3;
  localparam logic [2:0] CS_D256 = 3'h4;
  localparam logic [2:0] CS_D1K  = 3'h5;
  localparam logic [2:0] CS_EXTF = 3'h6;
  // Count sequence families
  typedef enum logic [2:0] {K_NORM, K_CTC, K_FAST, K_PHASE, K_PFC, K_RSVD} seq_kind_t;
  typedef enum logic [1:0] {TS_FIX, TS_CAP, TS_CMPA} top_src_t;
endpackage
